// File: rtl/fthc_pkg.sv
/*
  Constants, state codes and the state record for the host controller that
  drives a clockless fall-through FIFO through its pins.
  Assumes one 20 MHz system clock; all pin timing is rounded to its cycles.
*/
package fthc_pkg;

  // ==========================================================================
  // Geometry
  // ==========================================================================
  // Word width and depth of one device.
  localparam int WORD_W = 5;
  localparam int DEPTH = 64;
  // Devices placed side by side; their flags are combined by AND.
  localparam int DEV_COUNT = 1;
  // Width of the synchronised pin bundle: word, ready-in flags, ready-out flags.
  localparam int SYNC_W = WORD_W + 2 * DEV_COUNT;
  localparam int SYNC_WORD_LSB = 0;
  localparam int SYNC_DIR_LSB = WORD_W;
  localparam int SYNC_DOR_LSB = WORD_W + DEV_COUNT;

  // ==========================================================================
  // Timing
  // ==========================================================================
  // System clock period in nanoseconds.
  localparam int CLK_NS = 50;
  // Least shift-in pulse width, high or low, in nanoseconds.
  localparam int SI_WIDTH_NS = 9;
  // Least shift-out pulse width, high or low, in nanoseconds.
  localparam int SO_WIDTH_NS = 14;
  // Least master clear low width, in nanoseconds.
  localparam int MR_LOW_NS = 26;
  // Least time from master clear release to shift-in, in nanoseconds.
  localparam int MR_REMOVAL_NS = 18;
  // Least data hold after the shift-in strobe falls, in nanoseconds.
  localparam int DATA_HOLD_NS = 30;

  // Least times round up to whole cycles.
  localparam int SI_CYC_I = (SI_WIDTH_NS + CLK_NS - 1) / CLK_NS;
  localparam int SO_CYC_I = (SO_WIDTH_NS + CLK_NS - 1) / CLK_NS;
  localparam int MR_CYC_I = (MR_LOW_NS + CLK_NS - 1) / CLK_NS;
  localparam int REM_CYC_I = (MR_REMOVAL_NS + CLK_NS - 1) / CLK_NS;
  localparam int HOLD_CYC_I = (DATA_HOLD_NS + CLK_NS - 1) / CLK_NS;
  // The low phase of shift-in must cover both its width and the data hold.
  localparam int WLOW_CYC_I = (HOLD_CYC_I > SI_CYC_I) ? HOLD_CYC_I : SI_CYC_I;

  // Counter width and the cycle counts at that width.
  localparam int CNT_W = 3;
  localparam logic [CNT_W-1:0] SI_CYC = CNT_W'(SI_CYC_I);
  localparam logic [CNT_W-1:0] SO_CYC = CNT_W'(SO_CYC_I);
  localparam logic [CNT_W-1:0] MR_CYC = CNT_W'(MR_CYC_I);
  localparam logic [CNT_W-1:0] REM_CYC = CNT_W'(REM_CYC_I);
  localparam logic [CNT_W-1:0] WLOW_CYC = CNT_W'(WLOW_CYC_I);
  localparam logic [CNT_W-1:0] CNT_ONE = 3'h1;
  localparam logic [CNT_W-1:0] CNT_ZERO = 3'h0;

  // ==========================================================================
  // States
  // ==========================================================================
  // Write side: idle, strobe high, strobe low with data held.
  typedef enum logic [1:0] {
    W_IDLE = 2'b00,
    W_HIGH = 2'b01,
    W_LOW = 2'b10
  } fthc_wr_state_t;

  // Read side: idle, strobe high (unload), strobe low (advance).
  typedef enum logic [1:0] {
    R_IDLE = 2'b00,
    R_HIGH = 2'b01,
    R_LOW = 2'b10
  } fthc_rd_state_t;

  // Clear sequencer: running, clear held low, removal wait.
  typedef enum logic [1:0] {
    C_RUN = 2'b00,
    C_LOW = 2'b01,
    C_REMOVE = 2'b10
  } fthc_clr_state_t;

  // Whole state of the controller.
  typedef struct packed {
    fthc_wr_state_t wr_st;
    fthc_rd_state_t rd_st;
    fthc_clr_state_t clr_st;
    logic [CNT_W-1:0] cnt_w;
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_c;
    logic si;
    logic [WORD_W-1:0] word;
    logic so_n;
    logic mr_n;
    logic oe_n;
    logic wr_ready;
    logic rd_valid;
    logic [WORD_W-1:0] rd_data;
    logic dor_q;
    logic busy;
  } fthc_state_t;

  // State of the pin synchroniser.
  typedef struct packed {
    logic [SYNC_W-1:0] stage1;
    logic [SYNC_W-1:0] stage2;
  } fthc_sync_t;

endpackage

// File: rtl/fthc_sync.sv
/*
  Two-flop synchroniser for the bundle of pins that the FIFO drives.
  Assumes the pins change with no relation to sys_clk_i.
*/
`timescale 1ns/1ps

module fthc_sync (
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  input wire logic [fthc_pkg::SYNC_W-1:0] async_i,
  output logic [fthc_pkg::SYNC_W-1:0] sync_o
);

  // ==========================================================================
  // Stages
  // ==========================================================================
  // Register copy and its next value.
  fthc_pkg::fthc_sync_t st;
  fthc_pkg::fthc_sync_t next_st;

  // The first stage feeds only the second, so a metastable bit settles there.
  always_comb begin
    next_st.stage1 = async_i;
    next_st.stage2 = st.stage1;
  end

  // Both stages clear to zero, which reads as "no flag" downstream.
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // The output comes straight from the second stage.
  assign sync_o = st.stage2;

endmodule

// File: rtl/fthc_host.sv
/*
  Host controller for a clockless fall-through FIFO: writes words through
  the shift-in strobe, reads them through the shift-out strobe, and clears
  the device. Assumes the FIFO pins sit outside the clock domain and that
  the board resolves the three-state read lines.
*/
// Summary of operation
// RULE_01: Device keeps 64 words in order.
// RULE_02: Shift-in rise captures word, ready-in drops.
// RULE_03: Word ripples forward, ready-in returns high.
// RULE_04: Full device ignores shift-in, ready-in low.
// RULE_05: Read vacancy bubbles up, ready-in rises.
// RULE_06: Held shift-in loads arriving vacancy automatically.
// RULE_07: Writer drops shift-in after every load.
// RULE_08: Master clear empties device, sets flags.
// RULE_09: Master clear drives read word low.
// RULE_10: Ready-out high means word valid; rise busies.
// RULE_11: Shift-out fall advances next word, ready-out rises.
// RULE_12: Empty device keeps ready-out low.
// RULE_13: Held shift-out lets word ripple to output.
// RULE_14: Held shift-out completes automatically, ready-out pulses.
// RULE_15: Reader drops shift-out after every unload.
// RULE_16: Burst writes ignore flag; overflow pulses ignored.
// RULE_17: Burst reads ignore flag, keep pulse widths.
// RULE_18: Side-by-side flags combine by AND.
// RULE_19: Cascade ready-out feeds next shift-in timing.
// RULE_20: Cascade ready-in pulse acts as shift-out.
// RULE_21: Cascade vacancy reaches first input later.
// RULE_22: Empty shift-out pulses change nothing.
// RULE_23: Output enable high floats read lines; the model drives the inverted word instead.
`timescale 1ns/1ps

module fthc_host (
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  input wire logic burst_i,
  input wire logic clear_i,
  input wire logic wr_valid_i,
  input wire logic [fthc_pkg::WORD_W-1:0] wr_data_i,
  output logic wr_ready_o,
  output logic rd_valid_o,
  output logic [fthc_pkg::WORD_W-1:0] rd_data_o,
  input wire logic rd_ready_i,
  output logic busy_o,
  output logic shift_in_strobe_o,
  output logic [fthc_pkg::WORD_W-1:0] write_word_o,
  input wire logic [fthc_pkg::DEV_COUNT-1:0] input_ready_flag_i,
  output logic shift_out_strobe_n_o,
  input wire logic [fthc_pkg::DEV_COUNT-1:0] output_ready_flag_i,
  input wire logic [fthc_pkg::WORD_W-1:0] read_word_i,
  output logic output_drive_en_n_o,
  output logic master_clear_n_o
);

  // ==========================================================================
  // Helpers
  // ==========================================================================
  // Combines the flags of devices placed side by side.
  function automatic logic all_set(
    input logic [fthc_pkg::DEV_COUNT-1:0] flags
  );
    all_set = &flags; // RULE_18
  endfunction

  // ==========================================================================
  // Pin synchronisation
  // ==========================================================================
  // Raw and synchronised pin bundles.
  logic [fthc_pkg::SYNC_W-1:0] pins_raw;
  logic [fthc_pkg::SYNC_W-1:0] pins_sync;
  // Synchronised word and combined flags.
  logic [fthc_pkg::WORD_W-1:0] word_s;
  logic dir_s;
  logic dor_s;

  assign pins_raw = {output_ready_flag_i, input_ready_flag_i, read_word_i};

  fthc_sync u_sync (
    .sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i),
    .async_i(pins_raw),
    .sync_o(pins_sync)
  );

  assign word_s = pins_sync[fthc_pkg::SYNC_WORD_LSB +: fthc_pkg::WORD_W];
  assign dir_s = all_set(
    pins_sync[fthc_pkg::SYNC_DIR_LSB +: fthc_pkg::DEV_COUNT]);
  assign dor_s = all_set(
    pins_sync[fthc_pkg::SYNC_DOR_LSB +: fthc_pkg::DEV_COUNT]);

  // ==========================================================================
  // State
  // ==========================================================================
  // Register copy and next value.
  fthc_pkg::fthc_state_t st;
  fthc_pkg::fthc_state_t next_st;
  // A word is taken from the user in this cycle.
  logic wr_take;

  // All behaviour: write strobe, read strobe and clear sequencing.
  always_comb begin
    next_st = st;
    wr_take = st.wr_ready && wr_valid_i;

    // A delivered word leaves when the user takes it.
    if (st.rd_valid && rd_ready_i) begin
      next_st.rd_valid = 1'b0;
    end

    // Write side.
    case (st.wr_st)
      fthc_pkg::W_IDLE: begin
        if (wr_take) begin
          // Ready was only offered while the flag was high, or in burst.
          next_st.si = 1'b1; // RULE_16
          next_st.word = wr_data_i;
          next_st.cnt_w = fthc_pkg::SI_CYC;
          next_st.wr_st = fthc_pkg::W_HIGH;
        end
      end
      fthc_pkg::W_HIGH: begin
        if (st.cnt_w > fthc_pkg::CNT_ONE) begin
          next_st.cnt_w = st.cnt_w - fthc_pkg::CNT_ONE;
        end else if (burst_i || !dir_s) begin
          // The device took the word; drop the strobe to finish it.
          next_st.si = 1'b0; // RULE_07
          next_st.cnt_w = fthc_pkg::WLOW_CYC;
          next_st.wr_st = fthc_pkg::W_LOW;
        end
      end
      fthc_pkg::W_LOW: begin
        // The word stays put through the hold time and the low width.
        if (st.cnt_w > fthc_pkg::CNT_ONE) begin
          next_st.cnt_w = st.cnt_w - fthc_pkg::CNT_ONE; // RULE_19
        end else begin
          next_st.wr_st = fthc_pkg::W_IDLE;
        end
      end
      default: begin
        next_st.si = 1'b0;
        next_st.wr_st = fthc_pkg::W_IDLE;
      end
    endcase

    // Read side.
    case (st.rd_st)
      fthc_pkg::R_IDLE: begin
        // Start only with room for the word and, outside burst, with the flag stable for
        // two samples, since the word follows the flag by a short delay.
        if (st.clr_st == fthc_pkg::C_RUN && !next_st.rd_valid &&
            (burst_i || (dor_s && st.dor_q))) begin
          // In burst an empty device gives no word back.
          next_st.rd_valid = dor_s && st.dor_q; // RULE_22
          next_st.rd_data = word_s;
          next_st.so_n = 1'b1; // RULE_17
          next_st.cnt_r = fthc_pkg::SO_CYC;
          next_st.rd_st = fthc_pkg::R_HIGH;
        end
      end
      fthc_pkg::R_HIGH: begin
        if (st.cnt_r > fthc_pkg::CNT_ONE) begin
          next_st.cnt_r = st.cnt_r - fthc_pkg::CNT_ONE;
        end else if (burst_i || !dor_s) begin
          // The output stage is busy; drop the strobe to advance it.
          next_st.so_n = 1'b0; // RULE_15
          next_st.cnt_r = fthc_pkg::SO_CYC;
          next_st.rd_st = fthc_pkg::R_LOW;
        end
      end
      fthc_pkg::R_LOW: begin
        if (st.cnt_r > fthc_pkg::CNT_ONE) begin
          next_st.cnt_r = st.cnt_r - fthc_pkg::CNT_ONE;
        end else begin
          next_st.rd_st = fthc_pkg::R_IDLE;
        end
      end
      default: begin
        next_st.so_n = 1'b0;
        next_st.rd_st = fthc_pkg::R_IDLE;
      end
    endcase

    // Clear sequencing overrides both sides.
    case (st.clr_st)
      fthc_pkg::C_RUN: begin
        if (clear_i) begin
          next_st.mr_n = 1'b0;
          next_st.cnt_c = fthc_pkg::MR_CYC;
          next_st.clr_st = fthc_pkg::C_LOW;
        end
      end
      fthc_pkg::C_LOW: begin
        if (st.cnt_c > fthc_pkg::CNT_ONE) begin
          next_st.cnt_c = st.cnt_c - fthc_pkg::CNT_ONE;
        end else begin
          next_st.mr_n = 1'b1;
          next_st.cnt_c = fthc_pkg::REM_CYC;
          next_st.clr_st = fthc_pkg::C_REMOVE;
        end
      end
      fthc_pkg::C_REMOVE: begin
        // Shift-in stays low until the removal time has passed.
        if (st.cnt_c > fthc_pkg::CNT_ONE) begin
          next_st.cnt_c = st.cnt_c - fthc_pkg::CNT_ONE;
        end else begin
          next_st.clr_st = fthc_pkg::C_RUN;
        end
      end
      default: begin
        next_st.mr_n = 1'b0;
        next_st.clr_st = fthc_pkg::C_LOW;
      end
    endcase
    if (next_st.clr_st != fthc_pkg::C_RUN) begin
      // A clear aborts any transfer and discards an undelivered word.
      next_st.si = 1'b0;
      next_st.so_n = 1'b0;
      next_st.wr_st = fthc_pkg::W_IDLE;
      next_st.rd_st = fthc_pkg::R_IDLE;
      next_st.rd_valid = 1'b0;
    end

    // Offer a write slot only when a strobe could start next cycle.
    next_st.wr_ready = (next_st.wr_st == fthc_pkg::W_IDLE) && !wr_take &&
                       (next_st.clr_st == fthc_pkg::C_RUN) &&
                       (burst_i || dir_s);
    next_st.dor_q = dor_s;
    next_st.busy = (next_st.clr_st != fthc_pkg::C_RUN);
    // Read lines are driven from the first cycle after reset, even while a clear is held.
    next_st.oe_n = 1'b0;
  end

  // Reset holds the device in clear, then runs the removal wait.
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st <= '0;
      st.clr_st <= fthc_pkg::C_LOW;
      st.cnt_c <= fthc_pkg::MR_CYC;
      st.oe_n <= 1'b1;
      st.busy <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign wr_ready_o = st.wr_ready;
  assign rd_valid_o = st.rd_valid;
  assign rd_data_o = st.rd_data;
  assign busy_o = st.busy;
  assign shift_in_strobe_o = st.si;
  assign write_word_o = st.word;
  assign shift_out_strobe_n_o = st.so_n;
  assign output_drive_en_n_o = st.oe_n;
  assign master_clear_n_o = st.mr_n;

  // ==========================================================================
  // Checks
  // ==========================================================================
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);

  si_drop_a: assert property ( // RULE_07
    (st.wr_st == fthc_pkg::W_HIGH && st.cnt_w == fthc_pkg::CNT_ONE &&
     !dir_s) |=> !shift_in_strobe_o)
    else $error("shift-in not dropped after load");

  so_drop_a: assert property ( // RULE_15
    (st.rd_st == fthc_pkg::R_HIGH && st.cnt_r == fthc_pkg::CNT_ONE &&
     !dor_s) |=> !shift_out_strobe_n_o)
    else $error("shift-out not dropped after unload");

  si_start_flag_a: assert property ( // RULE_16
    $rose(shift_in_strobe_o) |-> $past(burst_i) || $past(st.wr_ready))
    else $error("shift-in raised without flag or burst");

  si_burst_width_a: assert property ( // RULE_16
    ($rose(shift_in_strobe_o) && burst_i) |=> !shift_in_strobe_o ##1
    !shift_in_strobe_o)
    else $error("burst shift-in pulse width wrong");

  so_burst_width_a: assert property ( // RULE_17
    ($rose(shift_out_strobe_n_o) && burst_i) |=> !shift_out_strobe_n_o)
    else $error("burst shift-out pulse width wrong");

  word_hold_a: assert property ( // RULE_19
    (shift_in_strobe_o || $fell(shift_in_strobe_o)) &&
    $past(shift_in_strobe_o) |-> $stable(write_word_o))
    else $error("write word moved during shift-in");

  clear_removal_a: assert property ( // RULE_20
    $rose(master_clear_n_o) |-> !shift_in_strobe_o ##1 !shift_in_strobe_o)
    else $error("shift-in too soon after clear");

  rd_capture_a: assert property ( // RULE_18
    $rose(shift_out_strobe_n_o) && rd_valid_o |->
    $past(dor_s) && $past(st.dor_q))
    else $error("word delivered without stable combined flag");

endmodule

// File: verification/fthc_fifo_model.sv
/*
  Behavioural model of the clockless 5 x 64 fall-through FIFO device.
  Assumes the host drives the strobes, clear and output enable as pins.
*/
`timescale 1ns/1ps

module fthc_fifo_model #(
  parameter int RIPPLE_NS = 200,
  parameter int BUBBLE_NS = 600
) (
  input wire logic shift_in_strobe_i,
  input wire logic [fthc_pkg::WORD_W-1:0] write_word_i,
  output logic input_ready_flag_o,
  input wire logic shift_out_strobe_n_i,
  output logic output_ready_flag_o,
  output logic [fthc_pkg::WORD_W-1:0] read_word_o,
  input wire logic output_drive_en_n_i,
  input wire logic master_clear_n_i
);
  // ==========================================================================
  // Storage
  // ==========================================================================
  logic [fthc_pkg::WORD_W-1:0] mem[$]; // Words behind the output stage.
  int nmem = 0; // Mirror of the queue size, usable in a wait.
  logic [fthc_pkg::WORD_W-1:0] held; // Word in the input stage.
  logic [fthc_pkg::WORD_W-1:0] q = 5'h00; // Output-stage word.
  logic loading = 1'b0; // Input stage busy.
  logic outv = 1'b0; // Output stage holds a word.

  initial input_ready_flag_o = 1'b1;
  initial output_ready_flag_o = 1'b0;

  // Words held anywhere in the device.
  function automatic int count();
    return nmem + int'(outv) + int'(loading);
  endfunction

  // Vacancy travels to the input; a held strobe refills it at once.
  task automatic bubble();
    #BUBBLE_NS;
    if (master_clear_n_i) begin
      input_ready_flag_o = 1'b1;
      if (shift_in_strobe_i) begin
        #20 mem.push_back(write_word_i);
        nmem++;
        input_ready_flag_o = 1'b0;
      end
    end
  endtask

  // Empties the output stage; a full device starts a bubble-up.
  task automatic unload();
    outv = 1'b0;
    if (count() == fthc_pkg::DEPTH - 1 && !loading) begin
      fork
        bubble();
      join_none
    end
  endtask

  // ==========================================================================
  // Processes
  // ==========================================================================
  // Master clear overrides everything else.
  always @(negedge master_clear_n_i) begin
    mem.delete();
    nmem = 0;
    loading = 1'b0;
    outv = 1'b0;
    q = 5'h00;
    output_ready_flag_o = 1'b0;
    input_ready_flag_o = 1'b1;
  end

  // Capture only when ready; a full device ignores the pulse.
  always @(posedge shift_in_strobe_i) begin
    if (master_clear_n_i && input_ready_flag_o) begin
      held = write_word_i;
      loading = 1'b1;
      input_ready_flag_o = 1'b0;
    end
  end

  // The falling strobe lets the word ripple forward.
  always @(negedge shift_in_strobe_i) begin
    if (loading) begin
      mem.push_back(held);
      nmem++;
      loading = 1'b0;
      #25;
      if (master_clear_n_i && count() < fthc_pkg::DEPTH) begin
        input_ready_flag_o = 1'b1;
      end
    end
  end

  // Oldest word falls through to an empty output stage.
  always begin
    wait (master_clear_n_i && !outv && nmem > 0);
    #RIPPLE_NS;
    if (master_clear_n_i && !outv && nmem > 0) begin
      q = mem.pop_front();
      nmem--;
      outv = 1'b1;
      output_ready_flag_o = 1'b1;
      if (shift_out_strobe_n_i) begin
        #20 output_ready_flag_o = 1'b0;
        unload();
      end
    end
  end

  // Rising shift-out marks the output stage busy.
  always @(posedge shift_out_strobe_n_i) begin
    if (outv) output_ready_flag_o = 1'b0;
  end

  // Falling shift-out unloads; on an empty device nothing changes.
  always @(negedge shift_out_strobe_n_i) begin
    if (outv && !output_ready_flag_o) unload();
  end

  // Released lines show the inverted word so a stale value never matches.
  assign read_word_o = output_drive_en_n_i ? ~q : q;

endmodule

// File: verification/tb_fall_through_fifo_5x64.sv
/*
  Self-checking bench for the FIFO host controller and the device model.
  Assumes a 20 MHz clock and the user handshakes of the host controller.
*/
`timescale 1ns/1ps

module tb_fall_through_fifo_5x64;
  // ==========================================================================
  // Signals
  // ==========================================================================
  logic sys_clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic burst_i = 1'b0;
  logic clear_i = 1'b0;
  logic wr_valid_i = 1'b0;
  logic [4:0] wr_data_i = 5'h00;
  logic rd_ready_i = 1'b0;
  logic wr_ready, rd_valid, busy, si, so_n, oe_n, mr_n;
  logic [4:0] rd_data, wword, rword;
  logic [fthc_pkg::DEV_COUNT-1:0] dir, output_ready_flag;
  int fails = 0;
  int samples_checked = 0;
  int cycles = 0;
  bit took;
  logic [4:0] w;

  initial forever #25 sys_clk_i = ~sys_clk_i;

  fthc_host uut (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .burst_i(burst_i),
    .clear_i(clear_i), .wr_valid_i(wr_valid_i), .wr_data_i(wr_data_i),
    .wr_ready_o(wr_ready), .rd_valid_o(rd_valid), .rd_data_o(rd_data),
    .rd_ready_i(rd_ready_i), .busy_o(busy), .shift_in_strobe_o(si),
    .write_word_o(wword), .input_ready_flag_i(dir),
    .shift_out_strobe_n_o(so_n), .output_ready_flag_i(output_ready_flag),
    .read_word_i(rword), .output_drive_en_n_o(oe_n), .master_clear_n_o(mr_n));

  fthc_fifo_model dev (.shift_in_strobe_i(si), .write_word_i(wword),
    .input_ready_flag_o(dir[0]), .shift_out_strobe_n_i(so_n),
    .output_ready_flag_o(output_ready_flag[0]), .read_word_o(rword),
    .output_drive_en_n_i(oe_n), .master_clear_n_i(mr_n));

  // ==========================================================================
  // Checking and transfer tasks
  // ==========================================================================
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic check_bit(string what, logic exp, logic got);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic check_word(string what, logic [4:0] exp, logic [4:0] got);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Offers one word; gives up after limit edges so refusals can be seen.
  task automatic put_word(input logic [4:0] wd, input int limit,
                          output bit tk);
    @(posedge sys_clk_i);
    wr_valid_i <= 1'b1;
    wr_data_i <= wd;
    tk = 1'b0;
    for (int i = 0; i < limit && !tk; i++) begin
      @(posedge sys_clk_i);
      tk = (wr_ready === 1'b1);
    end
    wr_valid_i <= 1'b0;
  endtask

  // Accepts at most one word within limit edges.
  task automatic get_word(input int limit, output bit gt,
                          output logic [4:0] wd);
    @(posedge sys_clk_i);
    rd_ready_i <= 1'b1;
    gt = 1'b0;
    for (int i = 0; i < limit && !gt; i++) begin
      @(posedge sys_clk_i);
      gt = (rd_valid === 1'b1);
      wd = rd_data;
    end
    rd_ready_i <= 1'b0;
  endtask

  task automatic send(logic [4:0] wd);
    put_word(wd, 400, took);
    check_bit("write_taken", 1'b1, took);
  endtask

  task automatic expect_word(logic [4:0] exp);
    get_word(400, took, w);
    check_bit("read_valid", 1'b1, took);
    check_word("read_data", exp, w);
  endtask

  // Nothing may arrive from an empty device.
  task automatic expect_empty();
    get_word(40, took, w);
    check_bit("empty_read", 1'b0, took);
  endtask

  function automatic logic [4:0] pat(int i);
    return 5'(i * 7 + 3);
  endfunction

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  // Three words in, three out, in order.
  task automatic t_order();
    send(5'h0A);
    send(5'h15);
    send(5'h1F);
    expect_word(5'h0A);
    expect_word(5'h15);
    expect_word(5'h1F);
  endtask

  // The host register keeps one word, so 65 fit before refusal.
  task automatic t_fill();
    for (int i = 0; i < 65; i++) send(pat(i));
    put_word(5'h11, 60, took);
    check_bit("full_refused", 1'b0, took);
    expect_word(pat(0));
    send(5'h11);
    for (int i = 1; i < 65; i++) expect_word(pat(i));
    expect_word(5'h11);
    expect_empty();
  endtask

  // Clear in mid-run discards everything and zeroes the output word.
  task automatic t_clear();
    for (int i = 0; i < 3; i++) send(pat(i));
    repeat (10) @(posedge sys_clk_i);
    clear_i <= 1'b1;
    @(posedge sys_clk_i);
    clear_i <= 1'b0;
    #1;
    check_bit("busy", 1'b1, busy);
    check_bit("clear_pin", 1'b0, mr_n);
    repeat (4) @(posedge sys_clk_i);
    #1;
    check_word("cleared_word", 5'h00, rword);
    check_bit("ready_in", 1'b1, dir[0]);
    expect_empty();
    send(5'h15);
    expect_word(5'h15);
  endtask

  // Blind writes: the pulse that would overflow is dropped. The host holds
  // one word first, so its blind read pulses cannot strike a word in flight.
  task automatic t_burst();
    send(pat(0));
    for (int i = 0; i < 100 && rd_valid !== 1'b1; i++) begin
      @(posedge sys_clk_i);
    end
    check_bit("held_word", 1'b1, rd_valid);
    burst_i <= 1'b1;
    for (int i = 1; i < 66; i++) send(pat(i));
    repeat (20) @(posedge sys_clk_i);
    burst_i <= 1'b0;
    for (int i = 0; i < 65; i++) expect_word(pat(i));
    expect_empty();
    // Blind reads of an empty device deliver nothing and keep the last word.
    burst_i <= 1'b1;
    expect_empty();
    burst_i <= 1'b0;
    #1;
    check_word("last_word", pat(64), rword);
    check_bit("empty_after_burst", 1'b0, output_ready_flag[0]);
  endtask

  // ==========================================================================
  // Main sequence and hang guard
  // ==========================================================================
  initial begin
    repeat (4) @(posedge sys_clk_i);
    #1;
    check_bit("reset_clear", 1'b0, mr_n);
    check_bit("reset_oe", 1'b1, oe_n);
    repeat (4) @(posedge sys_clk_i);
    rstn_i <= 1'b1;
    repeat (4) @(posedge sys_clk_i);
    #1;
    check_bit("run_oe", 1'b0, oe_n);
    check_bit("run_busy", 1'b0, busy);
    check_bit("empty_flag", 1'b0, output_ready_flag[0]);
    t_order();
    t_fill();
    t_clear();
    t_burst();
    tally_and_finish();
  end

  // The whole run needs some 2500 cycles; 20000 means a hang.
  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      $display("mismatch run_cycles expected below 20000 seen %0d", cycles);
      tally_and_finish();
    end
  end

endmodule
